// [fdtf_core.sv]
`timescale 1ns/10ps
`include "fdtf_map.svh"
module fdtf_core #(
  parameter int CLK_MHZ = `FDTF_CLK_MHZ,
  parameter int FIFO_DEPTH = 32,
  parameter int STEP_UNIT_US = `FDTF_STEP_UNIT_US
) (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  // Task file port
  input  wire logic [2:0]          tf_addr_i,
  input  wire logic                tf_rd_i,
  input  wire logic                tf_wr_i,
  input  wire logic [15:0]         tf_wdata_i,
  output logic [15:0]              tf_rdata_o,
  // Fixed disk control register, head select 3 enable
  input  wire logic                head_hi_en_i,
  // Drive status pins (asynchronous)
  input  wire fdtf_pkg::fdtf_drv_t drv_i,
  // Media channel events
  input  wire fdtf_pkg::fdtf_media_t media_i,
  // Sector stream toward the media
  output logic                     wr_valid_o,
  input  wire logic                wr_ready_i,
  output logic [15:0]              wr_data_o,
  // Drive controls
  output logic                     step_o,
  output logic                     drive_sel_o,
  output logic [3:0]               head_o,
  output logic                     irq14_o
);
  localparam int UNIT_CYC = STEP_UNIT_US * CLK_MHZ;
  localparam int STEP_ZERO_CYC = `FDTF_STEP_ZERO_US * CLK_MHZ;

  typedef struct packed {
    logic [2:0][4:0]          sync;
    logic [7:0]               drvhead;
    logic [7:0]               seccnt;
    logic [7:0]               error;
    logic [7:0]               opcode;
    logic                     busy;
    logic                     bsr;
    logic                     err;
    logic                     corr;
    logic                     irq;
    logic [3:0]               rate;
    logic [9:0]               steps;
    logic [22:0]              timer;
    logic [8:0]               words;
    logic [2:0]               eccb;
    logic                     first;
    logic                     step;
    logic [15:0]              rdata;
    logic [4:0]               drvhold;
    logic [3:0]               head;
    fdtf_pkg::fdtf_state_t    state;
  } fdtf_st_t;
  fdtf_st_t s_q, s_d;

  logic                       f_valid, f_ready, f_in_ready;
  logic [15:0]                f_data;
  fdtf_pkg::fdtf_drv_t        drv_s;

  // Step period in clock cycles for a rate code
  function automatic logic [22:0] step_cycles(input logic [3:0] code);
    if (code == 4'h0) begin
      step_cycles = 23'(STEP_ZERO_CYC);
    end else begin
      step_cycles = 23'(UNIT_CYC * int'(code));
    end
  endfunction

  // Sectors to move, zero meaning 256
  function automatic logic [8:0] sectors(input logic [7:0] cnt);
    sectors = (cnt == 8'h00) ? 9'h100 : {1'b0, cnt};
  endfunction

  // Drive pins after three flops, change counted when last two agree
  assign drv_s = (s_q.sync[1] == s_q.sync[2]) ? fdtf_pkg::fdtf_drv_t'(s_q.sync[2])
                                               : fdtf_pkg::fdtf_drv_t'(s_q.drvhold);

  logic drive_ok;
  assign drive_ok = drv_s.ready && drv_s.seekdone && !drv_s.wfault;

  // Write data buffer between host and media
  fdtf_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (s_q.state == fdtf_pkg::FDTF_IDLE),
    .in_valid_i  (f_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (tf_wdata_i),
    .out_valid_o (wr_valid_o),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );
  assign f_ready = wr_ready_i;
  assign wr_data_o = f_data;
  assign f_valid = tf_wr_i && (tf_addr_i == `FDTF_REG_DATA) && s_q.bsr && s_q.opcode[4];

  // Status byte
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[`FDTF_ST_BUSY] = s_q.busy;
    status[`FDTF_ST_READY] = drv_s.ready;
    status[`FDTF_ST_WFAULT] = drv_s.wfault;
    status[`FDTF_ST_SEEKDONE] = drv_s.seekdone;
    status[`FDTF_ST_BSR] = s_q.bsr;
    status[`FDTF_ST_CORR] = s_q.corr;
    status[`FDTF_ST_INDEX] = drv_s.index;
    status[`FDTF_ST_ERR] = s_q.err;
  end

  // Command engine, registers and read mux
  always_comb begin
    logic cmd_wr;
    logic halt;
    cmd_wr = tf_wr_i && (tf_addr_i == `FDTF_REG_STATCMD);
    halt = 1'b0;
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], 5'(drv_i)};
    // Last agreed drive pin value, held while the last two flops disagree
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.drvhold = s_q.sync[2];
    end
    // Head lines registered; upper heads need control bit 3
    s_d.head = {s_q.drvhead[`FDTF_DH_HEAD_HI] & head_hi_en_i, s_q.drvhead[2:0]};
    s_d.step = 1'b0;
    // Register reads; busy mirrors status everywhere
    s_d.rdata = 16'h0000;
    if (tf_rd_i) begin
      if (s_q.busy) begin
        s_d.rdata = {8'h00, status};
      end else begin
        unique case (tf_addr_i)
          `FDTF_REG_ERROR:   s_d.rdata = {8'h00, s_q.error};
          `FDTF_REG_SECCNT:  s_d.rdata = {8'h00, s_q.seccnt};
          `FDTF_REG_DRVHEAD: s_d.rdata = {8'h00, s_q.drvhead};
          `FDTF_REG_STATCMD: s_d.rdata = {8'h00, status};
          default:           s_d.rdata = 16'h0000;
        endcase
      end
      if (tf_addr_i == `FDTF_REG_STATCMD) begin
        s_d.irq = 1'b0;
      end
    end
    // Any command write drops the interrupt, unless a completion in the same cycle raises it
    if (cmd_wr) begin
      s_d.irq = 1'b0;
    end
    // Task file writes accepted while not busy
    if (tf_wr_i && !s_q.busy) begin
      if (tf_addr_i == `FDTF_REG_SECCNT) begin
        s_d.seccnt = tf_wdata_i[7:0];
      end
      if (tf_addr_i == `FDTF_REG_DRVHEAD) begin
        s_d.drvhead = tf_wdata_i[7:0];
      end
    end
    unique case (s_q.state)
      fdtf_pkg::FDTF_IDLE: begin
        if (cmd_wr && !s_q.busy) begin
          s_d.irq = 1'b0;
          s_d.bsr = 1'b0;
          s_d.err = 1'b0;
          s_d.corr = 1'b0;
          s_d.error = 8'h00;
          s_d.opcode = tf_wdata_i[7:0];
          s_d.busy = 1'b1;
          s_d.steps = '0;
          s_d.words = '0;
          s_d.first = 1'b1;
          s_d.timer = '0;
          s_d.state = fdtf_pkg::FDTF_DONE;
          if (!drive_ok) begin
            s_d.error[`FDTF_ER_ABORT] = 1'b1;
          end else if (tf_wdata_i[7:4] == `FDTF_OP_RESTORE || tf_wdata_i[7:4] == `FDTF_OP_SEEK) begin
            s_d.rate = tf_wdata_i[3:0];
            s_d.state = fdtf_pkg::FDTF_STEP;
          end else if (tf_wdata_i[7:2] == `FDTF_OP_READ || tf_wdata_i[7:2] == `FDTF_OP_WRITE
                       || tf_wdata_i[7:1] == `FDTF_OP_VERIFY) begin
            s_d.words = sectors(s_q.seccnt);
            s_d.state = fdtf_pkg::FDTF_MEDIA;
            if (tf_wdata_i[4] && tf_wdata_i[7:2] == `FDTF_OP_WRITE) begin
              s_d.bsr = 1'b1;
              s_d.state = fdtf_pkg::FDTF_XFER;
            end
          end else if (tf_wdata_i[7:0] == `FDTF_OP_FORMAT) begin
            s_d.words = `FDTF_SECTOR_WORDS;
            s_d.bsr = 1'b1;
            s_d.state = fdtf_pkg::FDTF_XFER;
          end else if (tf_wdata_i[7:0] == `FDTF_OP_DIAG) begin
            s_d.rate = `FDTF_STEP_SLOWEST;
            s_d.error = `FDTF_DIAG_OK;
          end else if (tf_wdata_i[7:0] != `FDTF_OP_SETPAR) begin
            s_d.error[`FDTF_ER_ABORT] = 1'b1;
          end
        end
      end
      fdtf_pkg::FDTF_STEP: begin
        // Restore steps until track zero, once per rate period; seek steps once, then waits one rate period
        if (s_q.opcode[7:4] == `FDTF_OP_RESTORE && drv_s.track0) begin
          s_d.state = fdtf_pkg::FDTF_DONE;
        end else if (s_q.steps == `FDTF_MAX_STEPS) begin
          s_d.error[`FDTF_ER_TRK0] = 1'b1;
          s_d.state = fdtf_pkg::FDTF_DONE;
        end else if (drv_s.seekdone) begin
          s_d.step = 1'b1;
          s_d.steps = s_q.steps + 10'h001;
          s_d.timer = step_cycles(s_q.rate);
          s_d.state = fdtf_pkg::FDTF_SWAIT;
        end
      end
      fdtf_pkg::FDTF_SWAIT: begin
        if (s_q.timer != '0) begin
          s_d.timer = s_q.timer - 23'h000001;
        end else if (s_q.opcode[7:4] == `FDTF_OP_SEEK) begin
          s_d.state = fdtf_pkg::FDTF_DONE;
        end else begin
          s_d.state = fdtf_pkg::FDTF_STEP;
        end
      end
      fdtf_pkg::FDTF_MEDIA: begin
        // Wait for a sector from the media channel
        if (!drive_ok) begin
          halt = 1'b1;
        end else if (media_i.done) begin
          s_d.corr = s_q.corr | media_i.corrected;
          s_d.error[`FDTF_ER_IDNF] = media_i.idnf;
          s_d.error[`FDTF_ER_BADBLK] = media_i.badblk;
          s_d.error[`FDTF_ER_ECC] = media_i.uncorrectable && !s_q.opcode[1];
          s_d.words = s_q.words - 9'h001;
          if (media_i.idnf || media_i.badblk) begin
            halt = 1'b1;
          end else if (s_q.opcode[7:2] == `FDTF_OP_READ) begin
            s_d.bsr = 1'b1;
            s_d.irq = 1'b1;
            s_d.busy = 1'b0;
            s_d.eccb = s_q.opcode[1] ? `FDTF_ECC_BYTES : 3'h0;
            s_d.state = fdtf_pkg::FDTF_HOLD;
          end else if (s_q.words == 9'h001 || s_q.opcode == `FDTF_OP_FORMAT) begin
            s_d.state = fdtf_pkg::FDTF_DONE;
          end else if (s_q.opcode[7:2] == `FDTF_OP_WRITE) begin
            s_d.bsr = 1'b1;
            s_d.irq = 1'b1;
            s_d.state = fdtf_pkg::FDTF_XFER;
          end
        end
      end
      fdtf_pkg::FDTF_XFER: begin
        // Host loads one sector (or the format table) into the buffer
        s_d.busy = 1'b0;
        if (f_valid && f_in_ready) begin
          s_d.timer = s_q.timer + 23'h000001;
          if (s_q.timer[7:0] == 8'hff) begin
            s_d.bsr = 1'b0;
            s_d.busy = 1'b1;
            s_d.timer = '0;
            s_d.state = fdtf_pkg::FDTF_MEDIA; // buffer is flushed at idle even if the table has not drained
          end
        end
      end
      fdtf_pkg::FDTF_HOLD: begin
        // Read sector waits for the host to empty it
        if (tf_rd_i && tf_addr_i == `FDTF_REG_DATA) begin
          s_d.timer = s_q.timer + 23'h000001;
          if (s_q.timer[7:0] == 8'hff) begin
            s_d.timer = '0;
            s_d.bsr = 1'b0;
            s_d.busy = 1'b1;
            if (s_q.error[`FDTF_ER_ECC] || s_q.words == 9'h000) begin
              s_d.busy = 1'b0;
              s_d.err = s_q.error[`FDTF_ER_ECC];
              s_d.state = fdtf_pkg::FDTF_IDLE;
            end else begin
              s_d.state = fdtf_pkg::FDTF_MEDIA;
            end
          end
        end
      end
      fdtf_pkg::FDTF_ECCB: begin
        s_d.state = fdtf_pkg::FDTF_DONE;
      end
      fdtf_pkg::FDTF_DONE: begin
        s_d.busy = 1'b0;
        s_d.irq = 1'b1;
        s_d.err = (s_q.error != 8'h00) && (s_q.opcode != `FDTF_OP_DIAG)
                  && (s_q.opcode != `FDTF_OP_FORMAT);
        s_d.state = fdtf_pkg::FDTF_IDLE;
      end
      default: s_d.state = fdtf_pkg::FDTF_IDLE;
    endcase
    if (halt) begin
      s_d.error[`FDTF_ER_ABORT] = !drive_ok;
      s_d.state = fdtf_pkg::FDTF_DONE;
    end
  end

  // State register; stepping rate starts slowest
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.drvhead <= `FDTF_DH_RESET;
      s_q.rate <= `FDTF_STEP_SLOWEST;
      s_q.error <= `FDTF_DIAG_OK;
      s_q.state <= fdtf_pkg::FDTF_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs from flops
  assign tf_rdata_o  = s_q.rdata;
  assign step_o      = s_q.step;
  assign irq14_o     = s_q.irq;
  assign drive_sel_o = s_q.drvhead[`FDTF_DH_DRIVE];
  assign head_o      = s_q.head;
endmodule

// [fdtf_map.svh]
`ifndef FDTF_MAP_SVH
`define FDTF_MAP_SVH
// Task file register indices (low three address bits)
`define FDTF_REG_DATA      3'h0
`define FDTF_REG_ERROR     3'h1
`define FDTF_REG_SECCNT    3'h2
`define FDTF_REG_SECNUM    3'h3
`define FDTF_REG_CYLLO     3'h4
`define FDTF_REG_CYLHI     3'h5
`define FDTF_REG_DRVHEAD   3'h6
`define FDTF_REG_STATCMD   3'h7
// Status bit positions
`define FDTF_ST_BUSY       7
`define FDTF_ST_READY      6
`define FDTF_ST_WFAULT     5
`define FDTF_ST_SEEKDONE   4
`define FDTF_ST_BSR        3
`define FDTF_ST_CORR       2
`define FDTF_ST_INDEX      1
`define FDTF_ST_ERR        0
// Error bit positions
`define FDTF_ER_TRK0       1
`define FDTF_ER_ABORT      2
`define FDTF_ER_IDNF       4
`define FDTF_ER_ECC        6
`define FDTF_ER_BADBLK     7
// Drive/head fields
`define FDTF_DH_DRIVE      4
`define FDTF_DH_HEAD_HI    3
`define FDTF_DH_RESET      8'ha0
// Opcode upper nibbles, six and seven bit prefixes, and full codes
`define FDTF_OP_RESTORE    4'h1
`define FDTF_OP_SEEK       4'h7
`define FDTF_OP_READ       6'h08
`define FDTF_OP_WRITE      6'h0c
`define FDTF_OP_FORMAT     8'h50
`define FDTF_OP_VERIFY     7'h20
`define FDTF_OP_DIAG       8'h88
`define FDTF_OP_SETPAR     8'h91
// Step rate: code 0 is 3.5 ms, code n is n * 0.5 ms
`define FDTF_STEP_UNIT_US  500
`define FDTF_STEP_ZERO_US  3500
`define FDTF_STEP_SLOWEST  4'hf
`define FDTF_CLK_MHZ       200
`define FDTF_MAX_STEPS     10'h3ff
`define FDTF_SECTOR_WORDS  9'h100
`define FDTF_ECC_BYTES     3'h4
`define FDTF_FMT_GOOD      8'h00
`define FDTF_FMT_BAD       8'h80
`define FDTF_DIAG_OK       8'h01
`endif

// [fdtf_pkg.sv]
package fdtf_pkg;
  // Drive side status inputs, synchronised inside the core
  typedef struct packed {
    logic ready;
    logic wfault;
    logic seekdone;
    logic track0;
    logic index;
  } fdtf_drv_t;
  // Sector media events from the read channel
  typedef struct packed {
    logic done;
    logic corrected;
    logic uncorrectable;
    logic idnf;
    logic badblk;
  } fdtf_media_t;
  // Command engine states
  typedef enum logic [7:0] {
    FDTF_IDLE  = 8'h01,
    FDTF_STEP  = 8'h02,
    FDTF_SWAIT = 8'h04,
    FDTF_XFER  = 8'h08,
    FDTF_MEDIA = 8'h10,
    FDTF_ECCB  = 8'h20,
    FDTF_DONE  = 8'h40,
    FDTF_HOLD  = 8'h80
  } fdtf_state_t;
endpackage

// [fdtf_fifo.sv]
`timescale 1ns/10ps
module fdtf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        valid;
  } fdtf_fifo_st_t;
  fdtf_fifo_st_t s_q, s_d;
  logic push, pop;

  // Flags straight from the count
  assign in_ready_o  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = s_q.valid;
  assign out_data_o  = s_q.mem[s_q.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  // Pointer and storage update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i) begin
      s_d.wp  = '0;
      s_d.rp  = '0;
      s_d.cnt = '0;
    end
    s_d.valid = (s_d.cnt != '0);
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// [fdtf_core_monitor.sv]
`timescale 1ns/10ps
module fdtf_core_monitor (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  // Task file port
  input wire logic [2:0]  tf_addr_i,
  input wire logic        tf_rd_i,
  input wire logic        tf_wr_i,
  input wire logic [15:0] tf_wdata_i,
  input wire logic [15:0] tf_rdata_o,
  input wire logic        head_hi_en_i,
  // Sector stream and drive controls
  input wire logic        wr_valid_o,
  input wire logic        wr_ready_i,
  input wire logic [15:0] wr_data_o,
  input wire logic        step_o,
  input wire logic        drive_sel_o,
  input wire logic [3:0]  head_o,
  input wire logic        irq14_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Host access steps
  sequence s_stat_rd; tf_rd_i && tf_addr_i == 3'h7; endsequence
  sequence s_cmd_wr; tf_wr_i && tf_addr_i == 3'h7; endsequence
  sequence s_quick; s_cmd_wr ##0 (tf_wdata_i[7:0] == 8'h91 || tf_wdata_i[7:0] == 8'h88); endsequence
  // A read landing on a completion edge returns busy; the new interrupt wins then
  property p_irq_rd; s_stat_rd |=> !irq14_o || tf_rdata_o[7]; endproperty
  a_irq_rd: assert property (p_irq_rd) else $error("irq stayed up after status read");
  property p_irq_cmd; s_cmd_wr |=> !irq14_o; endproperty
  a_irq_cmd: assert property (p_irq_cmd) else $error("irq stayed up after command write");
  property p_irq_hold; irq14_o && !(tf_addr_i == 3'h7 && (tf_rd_i || tf_wr_i)) |=> irq14_o; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without a clearing access");
  property p_irq_quick; s_quick |=> !irq14_o ##1 irq14_o; endproperty
  a_irq_quick: assert property (p_irq_quick) else $error("irq not raised two cycles after command");
  property p_step_one; step_o |=> !step_o; endproperty
  a_step_one: assert property (p_step_one) else $error("step pulse longer than one cycle");
  property p_head_gate; !head_hi_en_i [*2] |-> !head_o[3]; endproperty
  a_head_gate: assert property (p_head_gate) else $error("upper head reached without enable");
  property p_sel; tf_wr_i && tf_addr_i == 3'h6 |=> drive_sel_o == $past(tf_wdata_i[4]); endproperty
  a_sel: assert property (p_sel) else $error("drive select not taken from write");
  property p_rd_idle; !tf_rd_i |=> tf_rdata_o == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
  property p_wr_hold; wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("sector word changed while stalled");
endmodule
bind fdtf_core fdtf_core_monitor i_mon (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tf_addr_i(tf_addr_i),
  .tf_rd_i(tf_rd_i), .tf_wr_i(tf_wr_i), .tf_wdata_i(tf_wdata_i), .tf_rdata_o(tf_rdata_o),
  .head_hi_en_i(head_hi_en_i), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_data_o(wr_data_o),
  .step_o(step_o), .drive_sel_o(drive_sel_o), .head_o(head_o), .irq14_o(irq14_o));

// [fdtf_drive_model.sv]
`timescale 1ns/10ps
module fdtf_drive_model (
  // Clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  // Controls from the adapter and the bench
  input  wire logic          step_i,
  input  wire logic          wfault_i,
  input  wire logic          wr_valid_i,
  input  wire logic [15:0]   wr_data_i,
  // Drive status and stream acceptance
  output fdtf_pkg::fdtf_drv_t drv_o,
  output logic               wr_ready_o,
  output int                 steps_o,
  output int                 words_o,
  output logic               bad_o
);
  int pos;
  int settle;
  int rev;
  // Heads start three tracks out; seek complete drops for a while per step
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos <= 3; settle <= 0; rev <= 0; steps_o <= 0; words_o <= 0; bad_o <= 1'b0;
    end else begin
      rev <= (rev == 999) ? 0 : rev + 1;
      settle <= (settle > 0) ? settle - 1 : 0;
      if (step_i) begin
        steps_o <= steps_o + 1;
        settle <= 20;
        if (pos > 0) pos <= pos - 1;
      end
      // Each accepted word must follow the bench's counting pattern
      if (wr_valid_i && wr_ready_o) begin
        words_o <= words_o + 1;
        if (wr_data_i !== {8'(words_o + 1), 8'h00}) bad_o <= 1'b1;
      end
    end
  end
  // Stall one cycle in three; index once per revolution
  assign wr_ready_o = (rev % 3) != 0;
  assign drv_o = '{ready: 1'b1, wfault: wfault_i, seekdone: settle == 0, track0: pos == 0, index: rev < 4};
endmodule

// [fdtf_core_tb.sv]
`timescale 1ns/10ps
module fdtf_core_tb;
  logic                  clk, rst_n, rd, wr, hhi, wf, rdy, wvalid, step, sel, irq, bad;
  logic [2:0]            addr;
  logic [15:0]           wdata, rdata, wdat, v;
  logic [3:0]            head;
  fdtf_pkg::fdtf_drv_t   drv;
  fdtf_pkg::fdtf_media_t media;
  int                    n_fail, check_count, steps, words, cyc;
  fdtf_core #(.STEP_UNIT_US(1)) i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .tf_addr_i(addr), .tf_rd_i(rd),
    .tf_wr_i(wr), .tf_wdata_i(wdata), .tf_rdata_o(rdata), .head_hi_en_i(hhi), .drv_i(drv), .media_i(media),
    .wr_valid_o(wvalid), .wr_ready_i(rdy), .wr_data_o(wdat), .step_o(step), .drive_sel_o(sel),
    .head_o(head), .irq14_o(irq));
  fdtf_drive_model i_drv (.ref_clk_i(clk), .rst_n_i(rst_n), .step_i(step), .wfault_i(wf), .wr_valid_i(wvalid),
    .wr_data_i(wdat), .drv_o(drv), .wr_ready_o(rdy), .steps_o(steps), .words_o(words), .bad_o(bad));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Task file accesses, one strobe cycle each
  task automatic tf_write(input logic [2:0] a, input logic [15:0] d);
    @(negedge clk); addr = a; wdata = d; wr = 1'b1;
    @(negedge clk); wr = 1'b0;
  endtask
  task automatic tf_read(input logic [2:0] a, output logic [15:0] d);
    @(negedge clk); addr = a; rd = 1'b1;
    @(negedge clk); rd = 1'b0; d = rdata;
  endtask
  task automatic poll(input logic [15:0] mask, input logic [15:0] exp, input string what);
    int k;
    for (k = 0; k < 20000; k++) begin
      tf_read(3'h7, v);
      if (v[7] === 1'b0) break;
    end
    chk(v & mask, exp, what);
  endtask
  task automatic wait_irq();
    int k;
    for (k = 0; k < 20000 && irq !== 1'b1; k++) @(negedge clk);
    chk({15'h0, irq}, 16'h0001, "irq raised");
  endtask
  task automatic pulse(input fdtf_pkg::fdtf_media_t m);
    @(negedge clk); media = m;
    @(negedge clk); media = '0;
  endtask
  // Outgoing sector: BUFFER_SERVICE_REQUEST, 256 counted words, media done, then the end interrupt
  task automatic xfer_out(input logic [7:0] c);
    int i;
    int k;
    int base;
    tf_write(3'h7, {8'h00, c});
    poll(16'h0008, 16'h0008, "data request");
    base = words;
    for (i = 0; i < 256; i++) tf_write(3'h0, {8'(base + i + 1), 8'h00});
    for (k = 0; k < 2000 && words % 256 != 0; k++) @(negedge clk);
    pulse('{done: 1'b1, default: 1'b0});
    wait_irq();
    poll(16'h00fd, 16'h0050, "status after transfer");
  endtask
  initial begin
    {rd, wr, hhi, wf, addr, wdata, cyc, n_fail, check_count} = '0;
    media = '0;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (4) @(negedge clk);
    // Reset values
    tf_read(3'h6, v); chk(v, 16'h00a0, "drive head");
    tf_read(3'h1, v); chk(v, 16'h0001, "error");
    tf_read(3'h7, v); chk(v & 16'h00fd, 16'h0050, "status");
    // Parameters, diagnose, head and drive selection
    tf_write(3'h6, 16'h00a5); tf_write(3'h2, 16'h0011); tf_write(3'h7, 16'h0091);
    wait_irq(); poll(16'h00fd, 16'h0050, "set params");
    tf_write(3'h7, 16'h0088); wait_irq(); poll(16'h00fd, 16'h0050, "diagnose");
    tf_read(3'h1, v); chk(v, 16'h0001, "diag result");
    tf_write(3'h6, 16'h00ad); repeat (2) @(negedge clk); chk({12'h0, head}, 16'h0005, "head low");
    hhi = 1'b1; repeat (2) @(negedge clk); chk({12'h0, head}, 16'h000d, "head high");
    tf_write(3'h6, 16'h00b0); @(negedge clk); chk({15'h0, sel}, 16'h0001, "drive select");
    tf_write(3'h6, 16'h00a0);
    // Undefined opcodes abort; next command clears error
    for (int j = 0; j < 2; j++) begin
      tf_write(3'h7, j == 0 ? 16'h00ff : 16'h0000); wait_irq();
      poll(16'h00fd, 16'h0051, "abort status");
      tf_read(3'h1, v); chk(v & 16'h0004, 16'h0004, "abort bit");
    end
    tf_write(3'h7, 16'h0091); wait_irq(); poll(16'h00fd, 16'h0050, "error cleared");
    // Unfit drive refuses the command
    wf = 1'b1;
    repeat (4) @(negedge clk);
    tf_write(3'h7, 16'h0091); wait_irq(); poll(16'h00fd, 16'h0071, "write fault");
    wf = 1'b0;
    repeat (4) @(negedge clk);
    // Restore: busy hides registers, steps stop at track zero
    tf_write(3'h7, 16'h0011); tf_read(3'h6, v); chk(v & 16'h0080, 16'h0080, "busy mirror");
    poll(16'h00fd, 16'h0050, "restore"); chk(16'(steps), 16'h0003, "steps");
    tf_write(3'h7, 16'h0071); wait_irq(); poll(16'h00fd, 16'h0050, "seek");
    // Write one sector, then format a track
    tf_write(3'h2, 16'h0001); xfer_out(8'h30);
    tf_write(3'h2, 16'h0011); xfer_out(8'h50);
    chk({15'h0, bad}, 16'h0000, "stream words");
    // Read with a corrected sector, no end interrupt
    tf_write(3'h2, 16'h0001); tf_write(3'h7, 16'h0020);
    pulse('{done: 1'b1, corrected: 1'b1, default: 1'b0}); wait_irq();
    poll(16'h000c, 16'h000c, "corrected and request");
    repeat (256) tf_read(3'h0, v);
    repeat (20) @(negedge clk); chk({15'h0, irq}, 16'h0000, "no end irq");
    poll(16'h00f9, 16'h0050, "read done");
    tf_write(3'h7, 16'h0040); pulse('{done: 1'b1, default: 1'b0});
    wait_irq(); poll(16'h00fd, 16'h0050, "verify");
    close_out();
  end
endmodule
